/* design/eifm_bank.sv */
/*
  Event flag and enable bank: timer 2/3 and capture flags, group A and
  B enables, group interrupt requests and vector reads with clear.
  Assumes events are one-cycle pulses from logic on clk, and the CPU
  issues at most one read or write strobe per cycle.
*/
`default_nettype none
module eifm_bank
  import eifm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [15:0] cpu_wdata,
  output logic      [15:0] cpu_rdata,
  input  wire logic [7:0]  tmr23_events,
  input  wire logic [3:0]  capture_events,
  input  wire logic [10:0] grp_a_flags,
  input  wire logic [3:0]  capture_enable,
  output logic      [10:0] grp_a_enable,
  output logic             grp_a_irq_req,
  output logic             grp_b_irq_req,
  output logic             grp_c_irq_req
);

  logic [10:0] en_a_reg;
  logic [10:0] en_a_next;
  logic [7:0]  en_b_reg;
  logic [7:0]  en_b_next;
  logic [7:0]  flg_b_reg;
  logic [7:0]  flg_b_next;
  logic [3:0]  flg_c_reg;
  logic [3:0]  flg_c_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [7:0]  clr_b;
  logic [3:0]  clr_c;
  logic        rd_ok;
  logic        wr_en_a;
  logic        wr_en_b;
  logic        wr_flg_b;
  logic        wr_flg_c;
  logic        rd_vec_b;
  logic        rd_vec_c;
  logic [15:0] view_en_a;
  logic [15:0] view_en_b;
  logic [15:0] view_flg_b;
  logic [15:0] view_flg_c;
  logic [15:0] view_vec_b;
  logic [15:0] view_vec_c;

  eifm_vec_if #(.N(EIFM_FLG_B_W)) vec_b ();
  eifm_vec_if #(.N(EIFM_FLG_C_W)) vec_c ();

  function automatic logic hit(
    input logic [15:0] a,
    input logic [15:0] reg_addr
  );
    hit = (a == reg_addr);
  endfunction

  // Set after clear, so an event in the clearing cycle is never lost
  function automatic logic [7:0] flag_update(
    input logic [7:0] flags,
    input logic [7:0] clr,
    input logic [7:0] evt
  );
    flag_update = (flags & ~clr) | evt;
  endfunction

  // A write strobe wins over a read strobe in the same cycle
  assign rd_ok    = cpu_rd && !cpu_wr;
  assign wr_en_a  = cpu_wr && hit(cpu_addr, EIFM_ADDR_EN_A);
  assign wr_en_b  = cpu_wr && hit(cpu_addr, EIFM_ADDR_EN_B);
  assign wr_flg_b = cpu_wr && hit(cpu_addr, EIFM_ADDR_FLG_B);
  assign wr_flg_c = cpu_wr && hit(cpu_addr, EIFM_ADDR_FLG_C);
  assign rd_vec_b = rd_ok && hit(cpu_addr, EIFM_ADDR_VEC_B);
  assign rd_vec_c = rd_ok && hit(cpu_addr, EIFM_ADDR_VEC_C);

  // Reserved bits are never stored, so the padded views read them as zero
  assign view_en_a  = {5'h00, en_a_reg};
  assign view_en_b  = {8'h00, en_b_reg};
  assign view_flg_b = {8'h00, flg_b_reg};
  assign view_flg_c = {12'h000, flg_c_reg};
  assign view_vec_b = {10'h000, vec_b.id};
  assign view_vec_c = {10'h000, vec_c.id};

  assign vec_b.pend = flg_b_reg & en_b_reg;
  assign vec_c.pend = flg_c_reg & capture_enable;

  eifm_prio #(.N(EIFM_FLG_B_W), .BASE(EIFM_ID_B_BASE)) u_prio_b (
    .v (vec_b)
  );

  eifm_prio #(.N(EIFM_FLG_C_W), .BASE(EIFM_ID_C_BASE)) u_prio_c (
    .v (vec_c)
  );

  always_comb begin
    en_a_next = en_a_reg;
    if (wr_en_a) begin
      en_a_next = cpu_wdata[10:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      en_a_reg <= EIFM_EN_A_RST;
    end else begin
      en_a_reg <= en_a_next;
    end
  end

  always_comb begin
    en_b_next = en_b_reg;
    if (wr_en_b) begin
      en_b_next = cpu_wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      en_b_reg <= EIFM_EN_B_RST;
    end else begin
      en_b_reg <= en_b_next;
    end
  end

  // A vector read clears only the winner that it reports
  always_comb begin
    clr_b = '0;
    if (wr_flg_b) begin
      clr_b = cpu_wdata[7:0];
    end else if (rd_vec_b) begin
      clr_b = vec_b.hit;
    end
    flg_b_next = flag_update(flg_b_reg, clr_b, tmr23_events);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flg_b_reg <= EIFM_FLG_B_RST;
    end else begin
      flg_b_reg <= flg_b_next;
    end
  end

  always_comb begin
    clr_c = '0;
    if (wr_flg_c) begin
      clr_c = cpu_wdata[3:0];
    end else if (rd_vec_c) begin
      clr_c = vec_c.hit;
    end
    flg_c_next = 4'(flag_update({4'h0, flg_c_reg}, {4'h0, clr_c}, {4'h0, capture_events}));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flg_c_reg <= EIFM_FLG_C_RST;
    end else begin
      flg_c_reg <= flg_c_next;
    end
  end

  // Read data stands one cycle and falls back to zero, so no stale word lingers
  always_comb begin
    rdata_next = EIFM_RDATA_RST;
    if (rd_ok) begin
      unique case (cpu_addr)
        EIFM_ADDR_EN_A: begin
          rdata_next = view_en_a;
        end
        EIFM_ADDR_EN_B: begin
          rdata_next = view_en_b;
        end
        EIFM_ADDR_FLG_B: begin
          rdata_next = view_flg_b;
        end
        EIFM_ADDR_FLG_C: begin
          rdata_next = view_flg_c;
        end
        EIFM_ADDR_VEC_B: begin
          rdata_next = view_vec_b;
        end
        EIFM_ADDR_VEC_C: begin
          rdata_next = view_vec_c;
        end
        default: begin
          rdata_next = EIFM_RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= EIFM_RDATA_RST;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign cpu_rdata     = rdata_reg;
  assign grp_a_enable  = en_a_reg;
  // Group B and C requests follow the registered flags, so they drop the cycle after a clear; group A follows grp_a_flags directly
  assign grp_a_irq_req = |(grp_a_flags & en_a_reg);
  assign grp_b_irq_req = |vec_b.pend;
  assign grp_c_irq_req = |vec_c.pend;

endmodule
`default_nettype wire

/* design/eifm_prio.sv */
/*
  Fixed-priority encoder: lowest pending bit wins, identifier is base
  plus bit index, none pending gives zero.
  Assumes pending bits are already flag-and-enable.
*/
`default_nettype none
module eifm_prio
  import eifm_pkg::*;
#(
  parameter int         N    = 8,
  parameter logic [5:0] BASE = 6'h01
) (
  eifm_vec_if.enc v
);
  always_comb begin
    v.id  = EIFM_ID_NONE;
    v.hit = '0;
    // Walk downward so the lowest set bit is the last written
    for (int i = N - 1; i >= 0; i--) begin
      if (v.pend[i]) begin
        v.id  = BASE + 6'(i);
        v.hit = N'(1) << i;
      end
    end
  end
endmodule
`default_nettype wire

/* inc/eifm_pkg.sv */
/*
  Constants for the event flag and enable bank: register addresses,
  field widths, reset values and vector identifiers.
  Assumes a 16-bit word-addressed CPU data bus.
*/
`default_nettype none
package eifm_pkg;
  localparam logic [15:0] EIFM_ADDR_EN_A  = 16'h742C;
  localparam logic [15:0] EIFM_ADDR_EN_B  = 16'h742D;
  localparam logic [15:0] EIFM_ADDR_FLG_B = 16'h7430;
  localparam logic [15:0] EIFM_ADDR_FLG_C = 16'h7431;
  localparam logic [15:0] EIFM_ADDR_VEC_B = 16'h7433;
  localparam logic [15:0] EIFM_ADDR_VEC_C = 16'h7434;

  localparam int EIFM_EN_A_W  = 11;
  localparam int EIFM_FLG_B_W = 8;
  localparam int EIFM_FLG_C_W = 4;
  localparam int EIFM_VEC_W   = 6;
  localparam int EIFM_DATA_W  = 16;

  localparam logic [10:0] EIFM_EN_A_RST  = 11'h000;
  localparam logic [7:0]  EIFM_EN_B_RST  = 8'h00;
  localparam logic [7:0]  EIFM_FLG_B_RST = 8'h00;
  localparam logic [3:0]  EIFM_FLG_C_RST = 4'h0;
  localparam logic [15:0] EIFM_RDATA_RST = 16'h0000;

  // Identifier of bit 0 of each group; bit n answers base + n
  localparam logic [5:0] EIFM_ID_B_BASE = 6'h27;
  localparam logic [5:0] EIFM_ID_C_BASE = 6'h33;
  localparam logic [5:0] EIFM_ID_NONE   = 6'h00;
endpackage
`default_nettype wire

/* inc/eifm_vec_if.sv */
/*
  Carrier between the bank and its priority encoders: pending bits in,
  winning identifier and one-hot winner out.
  Assumes both ends run on the same clock; the path is combinational.
*/
`default_nettype none
interface eifm_vec_if #(parameter int N = 8);
  logic [N-1:0] pend;
  logic [5:0]   id;
  logic [N-1:0] hit;
  modport enc  (input pend, output id, output hit);
  modport user (output pend, input id, input hit);
endinterface
`default_nettype wire

/* sim/eifm_bank_monitor.sv */
/* Port checks for the flag bank.
   Assumes one clock and synchronous active-high reset. */
`default_nettype none
module eifm_bank_chk
  import eifm_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_wr,
  input wire logic        cpu_rd,
  input wire logic [15:0] cpu_wdata,
  input wire logic [15:0] cpu_rdata,
  input wire logic [7:0]  tmr23_events,
  input wire logic [3:0]  capture_events,
  input wire logic [10:0] grp_a_flags,
  input wire logic [3:0]  capture_enable,
  input wire logic [10:0] grp_a_enable,
  input wire logic        grp_a_irq_req,
  input wire logic        grp_b_irq_req,
  input wire logic        grp_c_irq_req
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic rd_ok = cpu_rd && !cpu_wr;
  irq_a_level_a: assert property (grp_a_irq_req == |(grp_a_flags & grp_a_enable))
    else $error("group A request wrong");
  en_a_write_a: assert property (cpu_wr && cpu_addr == EIFM_ADDR_EN_A
    |=> {5'h00, grp_a_enable} == ($past(cpu_wdata) & 16'h07ff))
    else $error("enable A write lost");
  reset_clear_a: assert property ($fell(rst) |-> grp_a_enable == 0 && cpu_rdata == 0 && !grp_b_irq_req)
    else $error("not clear after reset");
  flg_b_rsvd_a: assert property (rd_ok && cpu_addr == EIFM_ADDR_FLG_B |=> cpu_rdata[15:8] == 0)
    else $error("flag B upper byte set");
  flg_c_rsvd_a: assert property (rd_ok && cpu_addr == EIFM_ADDR_FLG_C |=> cpu_rdata[15:4] == 0)
    else $error("capture upper bits set");
  en_a_read_a: assert property (rd_ok && cpu_addr == EIFM_ADDR_EN_A |=> cpu_rdata == {5'h00, $past(grp_a_enable)})
    else $error("enable A read wrong");
  vec_b_none_a: assert property (rd_ok && cpu_addr == EIFM_ADDR_VEC_B && !grp_b_irq_req |=> cpu_rdata == 0)
    else $error("empty vector not zero");
  cap_event_a: assert property ((capture_events & capture_enable) != 0 ##1 $stable(capture_enable) |-> grp_c_irq_req)
    else $error("capture event lost");
endmodule
bind eifm_bank eifm_bank_chk chk (
  .clk            (clk),
  .rst            (rst),
  .cpu_addr       (cpu_addr),
  .cpu_wr         (cpu_wr),
  .cpu_rd         (cpu_rd),
  .cpu_wdata      (cpu_wdata),
  .cpu_rdata      (cpu_rdata),
  .tmr23_events   (tmr23_events),
  .capture_events (capture_events),
  .grp_a_flags    (grp_a_flags),
  .capture_enable (capture_enable),
  .grp_a_enable   (grp_a_enable),
  .grp_a_irq_req  (grp_a_irq_req),
  .grp_b_irq_req  (grp_b_irq_req),
  .grp_c_irq_req  (grp_c_irq_req)
);
`default_nettype wire

/* sim/eifm_cpu.sv */
/* CPU bus model: one word access per call.
   Assumes signals move 2 ns after a rising clk edge. */
`default_nettype none
module eifm_cpu (
  input  wire logic        clk,
  output logic      [15:0] addr,
  output logic             wr,
  output logic             rd,
  output logic      [15:0] wdata,
  input  wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {addr, wr, rd, wdata} = '0;
  // Data inverted once released, never left stale
  task automatic acc(input logic w, input logic [15:0] a, d, output logic [15:0] q);
    @(posedge clk) #2;
    {wr, rd, addr, wdata} = {w, !w, a, d};
    @(posedge clk) #2;
    {wr, rd, wdata} = {2'h0, ~d};
    q = rdata;
  endtask
endmodule
`default_nettype wire

/* sim/test_event_irq_flag_mask_bank.sv */
/* Bench for the flag bank against an integer model.
   Assumes the CPU model and the bound checker. */
`default_nettype none
module test_event_irq_flag_mask_bank
  import eifm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, rst = 1, wr, rd, irq_a, irq_b, irq_c;
  logic [15:0] addr, wdata, rdata, q;
  logic [10:0] fa = 0, en_a;
  logic [7:0]  ev8 = 0;
  logic [3:0]  ev4 = 0, cen = 0;
  logic [31:0] seed = 32'h92cf_3fc4, w1, w2;
  int          mismatches = 0, cmp_count = 0, m_ea, m_eb, m_fb = 0, m_fc = 0;
  always #12.5 clk = ~clk;
  eifm_cpu cpu (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata));
  eifm_bank dut (.clk(clk), .rst(rst), .cpu_addr(addr), .cpu_wr(wr), .cpu_rd(rd), .cpu_wdata(wdata),
    .cpu_rdata(rdata), .tmr23_events(ev8), .capture_events(ev4), .grp_a_flags(fa), .capture_enable(cen),
    .grp_a_enable(en_a), .grp_a_irq_req(irq_a), .grp_b_irq_req(irq_b), .grp_c_irq_req(irq_c));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rdc(input logic [15:0] a, e);
    cpu.acc(1'h0, a, 16'h0, q);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task automatic pulse(input logic [7:0] b, input logic [3:0] c);
    @(posedge clk) #2;
    {ev8, ev4} = {b, c};
    @(posedge clk) #2;
    {ev8, ev4} = '0;
  endtask
  // Reads past the last winner must answer zero
  task automatic drain(input logic [15:0] a, input int base, inout int f, input int en, n);
    int i;
    repeat (n + 1) begin
      for (i = 0; i < n && !(((f & en) >> i) & 1); i++);
      f &= ~(1 << i);
      rdc(a, 16'(i < n ? base + i : 0));
    end
  endtask
  initial begin
    #(25 * 5000);
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    #2 rst = 0;
    rdc(EIFM_ADDR_EN_A, 0);
    rdc(EIFM_ADDR_EN_B, 0);
    rdc(EIFM_ADDR_FLG_B, 0);
    rdc(EIFM_ADDR_FLG_C, 0);
    rdc(16'h742f, 0);
    repeat (30) begin
      w1 = rnd();
      cpu.acc(1'h1, EIFM_ADDR_EN_A, w1[15:0], q);
      cpu.acc(1'h1, EIFM_ADDR_EN_B, w1[31:16], q);
      m_ea = w1[10:0];
      m_eb = w1[23:16];
      rdc(EIFM_ADDR_EN_A, 16'(m_ea));
      rdc(EIFM_ADDR_EN_B, 16'(m_eb));
      chk("enable A out", 16'(en_a), 16'(m_ea));
      w1 = rnd();
      w2 = rnd();
      {fa, cen} = w2[14:0];
      fork
        cpu.acc(1'h1, EIFM_ADDR_FLG_B, w1[15:0], q);
        pulse(w1[23:16], w1[27:24]);
      join
      cpu.acc(1'h1, EIFM_ADDR_FLG_C, w2[31:16], q);
      m_fb = m_fb & ~w1[7:0] | w1[23:16];
      m_fc = (m_fc | w1[27:24]) & ~w2[19:16];
      rdc(EIFM_ADDR_FLG_B, 16'(m_fb));
      rdc(EIFM_ADDR_FLG_C, 16'(m_fc));
      chk("irq", {irq_a, irq_b, irq_c}, {|(fa & m_ea), |(m_fb & m_eb), |(m_fc & cen)});
      drain(EIFM_ADDR_VEC_B, EIFM_ID_B_BASE, m_fb, m_eb, 8);
      drain(EIFM_ADDR_VEC_C, EIFM_ID_C_BASE, m_fc, cen, 4);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
